/* File: hdl/codec_pkg.sv */
// constants shared by the codec housekeeping block
package codec_pkg;
  // serial frame shape
  localparam int FRAME_BITS = 64;
  localparam int IDX_W      = 6;
  localparam int PORTS      = 2;
  localparam int PRE_W      = 4;
  localparam int PRE_DIV    = 4;   // master clock edges per serial bit at divide-by-one
  localparam logic [IDX_W-1:0] LAST_IDX = 6'h3F;
  localparam logic [IDX_W-1:0] GPI_IDX  = 6'h10;  // start of input word one
  localparam logic [IDX_W-1:0] GPO_IDX  = 6'h08;  // middle of output word zero

  // frame field positions (bit 63 travels first)
  localparam int F_SAMPLE_HI = 63;
  localparam int F_SAMPLE_LO = 48;
  localparam int F_GPO_HI    = 63;
  localparam int F_GPO_LO    = 56;
  localparam int F_GPI_HI    = 31;
  localparam int F_GPI_LO    = 24;
  localparam int F_WDATA_HI  = 31;
  localparam int F_WDATA_LO  = 24;
  localparam int F_WR        = 23;
  localparam int F_ADDR_HI   = 20;
  localparam int F_ADDR_LO   = 16;
  localparam int F_OVF_HI    = 19;
  localparam int F_OVF_LO    = 16;
  localparam int F_RDATA_HI  = 15;
  localparam int F_RDATA_LO  = 8;
  localparam int F_CAL_HI    = 1;
  localparam int F_CAL_LO    = 0;

  // register map
  localparam int REG_COUNT = 32;
  localparam int REG_AW    = 5;
  localparam logic [REG_AW-1:0] REG_LINE1_GAIN = 5'h01;
  localparam logic [REG_AW-1:0] REG_LINE2_GAIN = 5'h02;
  localparam logic [REG_AW-1:0] REG_LINE3_GAIN = 5'h03;
  localparam logic [REG_AW-1:0] REG_MONO_CTRL  = 5'h0C;
  localparam logic [REG_AW-1:0] REG_M2_IN_CTRL = 5'h0F;
  localparam logic [REG_AW-1:0] REG_GPIO_DIR   = 5'h12;
  localparam logic [REG_AW-1:0] REG_DIG_CTRL   = 5'h13;
  localparam logic [REG_AW-1:0] REG_MODE       = 5'h14;
  localparam logic [REG_AW-1:0] REG_OVF_CLR    = 5'h15;

  // reset values: bit 7 = unmute, bits 6:0 = signed gain in dB
  localparam logic [7:0] LINE_GAIN_RST = 8'h68;  // muted, -24 dB
  localparam logic [7:0] MONO_RST      = 8'hF6;  // mono path unmuted, -10 dB
  localparam logic [7:0] M2_IN_RST     = 8'h7C;  // muted, -4 dB
  localparam logic [7:0] ZERO_RST      = 8'h00;  // muted, 0 dB, all off

  // mode register fields
  localparam int MODE_SAMPLE_RATE_DIVIDER_LO = 0;
  localparam int MODE_SAMPLE_RATE_DIVIDER_HI = 1;
  localparam int MODE_MAM     = 2;
  localparam int MODE_MOR     = 3;

  // calibration and data path
  localparam int CAL_SAMPLES = 1024;
  localparam int CAL_W       = 10;
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_SAMPLES - 1);
  localparam int SAMPLE_W    = 16;
  localparam int FIFO_DEPTH  = 32;
  localparam int GPIO_W      = 8;
  localparam int OVF_W       = 4;

  function automatic logic [7:0] reg_reset(input int idx);
    case (idx)
      int'(REG_LINE1_GAIN), int'(REG_LINE2_GAIN), int'(REG_LINE3_GAIN): reg_reset = LINE_GAIN_RST;
      int'(REG_MONO_CTRL):  reg_reset = MONO_RST;
      int'(REG_M2_IN_CTRL): reg_reset = M2_IN_RST;
      default:              reg_reset = ZERO_RST;
    endcase
  endfunction
endpackage

/* File: hdl/sample_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             clr_in,
  // fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign wr_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign rd_valid_out = (wr_ptr != rd_ptr);
  assign push         = wr_valid_in && wr_ready_out && !clr_in;
  assign pop          = rd_valid_out && rd_ready_in && !clr_in;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];

  // storage, no reset needed since empty hides it
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clr_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

/* File: hdl/codec_control.sv */
// codec housekeeping: serial ports, clocks, calibration, overflow, gpio
// Behaviour
// - writing one to a calibration trigger bit starts offset calibration
// - calibration lasts exactly 1024 sample periods of the converter
// - trigger bit returns to zero by itself when calibration finishes
// - while calibrating, inputs float, outputs held, sample words invalid; float output here asserted only in power-down
// - reset drops calibration results; no automatic calibration ever
// - sticky adc overflow flags in frame bits 16-19, cleared by register 21
// - surround mode: modem codecs clocked from audio master clock
// - surround mode: both frame syncs in phase
// - surround needs divider zero; modem rate then audio clock/4/64
// - register 18 sets each gpio pin direction, inputs after reset
// - gpio pin levels reported in out frame bits 24-31
// - output pins driven from input frame bits 56-63
// - inputs sampled at input word one, outputs change mid word zero
// - bit clocks and frame syncs derived from the two master clocks
// - reset clears counters and registers, frames restart from beginning
// - in reset bit clocks high, frame syncs low, outputs common mode
// - after reset all muted except mono path; toggle unmuted
// - after reset divider one, loopback, surround and power-downs off
// - reset gains: lines -24dB, mono -10dB, modem two input -4dB
// - reset zeroes every internal data path register except fifo storage
// - power-down keeps registers, resets clocks and data paths
// - gpio direction and levels handled through serial port one
`timescale 1ns/1ps
module codec_control
  import codec_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    power_down_pin_in,
  // master clocks (sampled)
  input  wire logic                    audio_master_clock_in,
  input  wire logic                    modem_master_clock_in,
  // serial port one
  output logic                         serial_bit_clock_one_out,
  output logic                         frame_sync_one_out,
  output logic                         serial_out_one_out,
  input  wire logic                    serial_in_one_in,
  // serial port two
  output logic                         serial_bit_clock_two_out,
  output logic                         frame_sync_two_out,
  output logic                         serial_out_two_out,
  // general purpose pins
  input  wire logic [GPIO_W-1:0]       gpio_in,
  output logic      [GPIO_W-1:0]       gpio_out,
  output logic      [GPIO_W-1:0]       gpio_oe_out,
  // converter side
  input  wire logic [SAMPLE_W-1:0]     adc_sample_in,
  input  wire logic                    adc_valid_in,
  output logic                         adc_ready_out,
  input  wire logic [OVF_W-1:0]        adc_overflow_in,
  // analog control
  output logic      [1:0]              cal_active_out,
  output logic      [1:0]              calibrated_out,
  output logic                         analog_float_out,
  output logic                         common_mode_out,
  output logic                         mute_toggle_out,
  output logic      [REG_COUNT*8-1:0]  settings_out
);
  localparam int SYNC_W = 4 + GPIO_W;

  // two-flop synchronisers for every pin input
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {gpio_in, serial_in_one_in, modem_master_clock_in,
                 audio_master_clock_in, power_down_pin_in};
      sync_b <= sync_a;
    end
  end

  logic              run;
  logic              sin_s;
  logic [GPIO_W-1:0] gpio_s;
  logic [1:0]        mclk_d;
  logic              audio_edge;
  logic              modem_edge;
  assign run    = sync_b[0];
  assign sin_s  = sync_b[3];
  assign gpio_s = sync_b[SYNC_W-1:4];

  // master clock rising edges, from the synchronised copies only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mclk_d <= '0;
    end else begin
      mclk_d <= sync_b[2:1];
    end
  end
  assign audio_edge = sync_b[1] && !mclk_d[0];
  assign modem_edge = sync_b[2] && !mclk_d[1];

  // register file and write path
  logic [7:0]        regs [REG_COUNT];
  logic              wr_en;
  logic [REG_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [REG_AW-1:0] rd_addr;
  logic [1:0]        cal_bits;
  logic [1:0]        cal_done;
  logic [OVF_W-1:0]  ovf;
  logic              surround;
  logic [1:0]        sample_rate_divider;

  assign sample_rate_divider     = regs[REG_MODE][MODE_SAMPLE_RATE_DIVIDER_HI:MODE_SAMPLE_RATE_DIVIDER_LO];
  // modem follows audio only when both mode bits are set
  assign surround = regs[REG_MODE][MODE_MAM] && regs[REG_MODE][MODE_MOR];

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_reg
      if (g == int'(REG_DIG_CTRL)) begin : g_dig
        // trigger bits: write one sets, hardware clears on completion
        always_ff @(posedge clk_in or negedge nrst_in) begin
          if (!nrst_in) begin
            regs[g] <= reg_reset(g);
          end else begin
            regs[g][7:2] <= (wr_en && wr_addr == REG_AW'(g)) ? wr_data[7:2] : regs[g][7:2];
            // set wins over completion; zero writes leave bits alone
            regs[g][1:0] <= (regs[g][1:0] & ~cal_done)
                          | ((wr_en && wr_addr == REG_AW'(g)) ? wr_data[1:0] : 2'b00);
          end
        end
      end else if (g == int'(REG_OVF_CLR)) begin : g_clr
        // write-only clear strobe, never stored
        always_ff @(posedge clk_in or negedge nrst_in) begin
          if (!nrst_in) begin
            regs[g] <= reg_reset(g);
          end else begin
            regs[g] <= reg_reset(g);
          end
        end
      end else begin : g_plain
        always_ff @(posedge clk_in or negedge nrst_in) begin
          if (!nrst_in) begin
            regs[g] <= reg_reset(g);
          end else if (wr_en && wr_addr == REG_AW'(g)) begin
            regs[g] <= wr_data;
          end
        end
      end
      assign settings_out[g*8 +: 8] = regs[g];
    end
  endgenerate
  assign cal_bits = regs[REG_DIG_CTRL][1:0];

  // clock generator and frame counters per port
  logic [PRE_W-1:0] pre [PORTS];
  logic [IDX_W-1:0] idx [PORTS];
  logic [PRE_W-1:0] next_pre [PORTS];
  logic [IDX_W-1:0] next_idx [PORTS];
  logic             next_sclk [PORTS];
  logic             sclk [PORTS];
  logic             fsync [PORTS];
  logic [PORTS-1:0] step;
  logic [PORTS-1:0] frame_start;
  logic [PORTS-1:0] rx_point;
  logic [FRAME_BITS-1:0] tx_word [PORTS];
  logic [FRAME_BITS-1:0] tx_shift [PORTS];

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic             edge_sel;
      logic [2:0]       n_fac;
      logic [PRE_W-1:0] lim;
      logic [PRE_W-1:0] half;
      // port two rides the audio clock in surround mode
      assign edge_sel = (p == 0 || surround) ? audio_edge : modem_edge;
      // modem side runs undivided unless it follows audio
      assign n_fac = (p == 0 || surround) ? 3'(sample_rate_divider) + 3'h1 : 3'h1;
      assign lim   = PRE_W'(PRE_DIV * int'(n_fac) - 1);
      assign half  = PRE_W'(PRE_DIV / 2 * int'(n_fac));

      always_comb begin
        next_pre[p] = pre[p];
        next_idx[p] = idx[p];
        step[p]     = 1'b0;
        rx_point[p] = 1'b0;
        if (edge_sel) begin
          if (pre[p] == lim) begin
            next_pre[p] = '0;
            next_idx[p] = idx[p] + 1'b1;
            step[p]     = 1'b1;
          end else begin
            next_pre[p] = pre[p] + 1'b1;
          end
          rx_point[p] = (pre[p] == half - 1'b1);
        end
        frame_start[p] = step[p] && (idx[p] == LAST_IDX);
        next_sclk[p]   = (next_pre[p] < half);
      end

      // counters and pins; both in reset and power-down the clocks park
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pre[p]   <= '0;
          idx[p]   <= '0;
          sclk[p]  <= 1'b1;
          fsync[p] <= 1'b0;
        end else if (!run) begin
          pre[p]   <= '0;
          idx[p]   <= '0;
          sclk[p]  <= 1'b1;
          fsync[p] <= 1'b0;
        end else if (p == 1 && surround) begin
          // copy port one so both frame syncs stay in phase
          pre[p]   <= next_pre[0];
          idx[p]   <= next_idx[0];
          sclk[p]  <= next_sclk[0];
          fsync[p] <= (next_idx[0] == '0);
        end else begin
          pre[p]   <= next_pre[p];
          idx[p]   <= next_idx[p];
          sclk[p]  <= next_sclk[p];
          fsync[p] <= (next_idx[p] == '0);
        end
      end

      // transmit shifter, msb first, reloaded at each frame start
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          tx_shift[p] <= '0;
        end else if (!run) begin
          tx_shift[p] <= '0;
        end else if (frame_start[p]) begin
          tx_shift[p] <= tx_word[p];
        end else if (step[p]) begin
          tx_shift[p] <= {tx_shift[p][FRAME_BITS-2:0], 1'b0};
        end
      end
    end
  endgenerate

  assign serial_bit_clock_one_out = sclk[0];
  assign serial_bit_clock_two_out = sclk[1];
  assign frame_sync_one_out       = fsync[0];
  assign frame_sync_two_out       = fsync[1];
  assign serial_out_one_out       = tx_shift[0][FRAME_BITS-1];
  assign serial_out_two_out       = tx_shift[1][FRAME_BITS-1];

  // receive shifter on port one, sampled mid bit
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] rx_frame;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_shift <= '0;
      rx_frame <= '0;
    end else if (!run) begin
      rx_shift <= '0;
      rx_frame <= '0;
    end else begin
      if (rx_point[0]) begin
        rx_shift <= {rx_shift[FRAME_BITS-2:0], sin_s};
      end
      if (frame_start[0]) begin
        rx_frame <= rx_shift;
      end
    end
  end

  // register access rides in each completed input frame
  assign wr_en   = frame_start[0] && rx_shift[F_WR];
  assign wr_addr = rx_shift[F_ADDR_HI:F_ADDR_LO];
  assign wr_data = rx_shift[F_WDATA_HI:F_WDATA_LO];
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_addr <= '0;
    end else if (frame_start[0]) begin
      rd_addr <= wr_addr;
    end
  end

  // gpio: inputs caught at word one, outputs moved mid word zero
  logic [GPIO_W-1:0] gpi;
  logic [GPIO_W-1:0] gpo;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gpi <= '0;
      gpo <= '0;
    end else begin
      if (step[0] && next_idx[0] == GPI_IDX) begin
        gpi <= gpio_s;
      end
      if (step[0] && next_idx[0] == GPO_IDX) begin
        gpo <= rx_frame[F_GPO_HI:F_GPO_LO];
      end
    end
  end
  assign gpio_out    = gpo;
  assign gpio_oe_out = regs[REG_GPIO_DIR];

  // sticky overflow flags; a new overflow beats a clear
  logic [OVF_W-1:0] ovf_clr;
  assign ovf_clr = (wr_en && wr_addr == REG_OVF_CLR) ? wr_data[OVF_W-1:0] : '0;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ovf <= '0;
    end else begin
      ovf <= (ovf & ~ovf_clr) | adc_overflow_in;
    end
  end

  // calibration length counted in frames of the port that clocks it
  logic [CAL_W-1:0] cal_cnt [2];
  logic [1:0]       cal_ok;
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_cal
      assign cal_done[c] = cal_bits[c] && frame_start[c] && cal_cnt[c] == CAL_LAST;
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cal_cnt[c] <= '0;
          cal_ok[c]  <= 1'b0;
        end else begin
          if (!cal_bits[c] || cal_done[c]) begin
            cal_cnt[c] <= '0;
          end else if (frame_start[c]) begin
            cal_cnt[c] <= cal_cnt[c] + 1'b1;
          end
          if (cal_done[c]) begin
            cal_ok[c] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign cal_active_out = cal_bits;
  assign calibrated_out = cal_ok;

  // sample fifo: converter fills, port one frames drain
  logic                rd_valid;
  logic [SAMPLE_W-1:0] rd_data;
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .clr_in       (!run),
    .wr_valid_in  (adc_valid_in),
    .wr_ready_out (adc_ready_out),
    .wr_data_in   (adc_sample_in),
    .rd_valid_out (rd_valid),
    .rd_ready_in  (frame_start[0]),
    .rd_data_out  (rd_data)
  );

  // outgoing frame contents
  always_comb begin
    tx_word[0] = '0;
    tx_word[1] = '0;
    // sample zeroed while calibrating since it cannot be trusted
    tx_word[0][F_SAMPLE_HI:F_SAMPLE_LO] = (rd_valid && !cal_bits[0]) ? rd_data : '0;
    tx_word[0][F_GPI_HI:F_GPI_LO]       = gpi;
    tx_word[0][F_OVF_HI:F_OVF_LO]       = ovf;
    tx_word[0][F_RDATA_HI:F_RDATA_LO]   = regs[rd_addr];
    tx_word[0][F_CAL_HI:F_CAL_LO]       = cal_bits;
    tx_word[1][F_CAL_HI:F_CAL_LO]       = cal_bits;
  end

  // analog status levels; common mode held through reset
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      common_mode_out  <= 1'b1;
      analog_float_out <= 1'b0;
      mute_toggle_out  <= 1'b1;
    end else begin
      common_mode_out  <= 1'b0;
      analog_float_out <= !run;
      mute_toggle_out  <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ovf_set_a: assert property (adc_overflow_in[0] |=> ovf[0])
    else $error("overflow flag not set");
  ovf_clear_a: assert property (ovf_clr[0] && !adc_overflow_in[0] |=> !ovf[0])
    else $error("overflow flag not cleared");
  cal_start_a: assert property (wr_en && wr_addr == REG_DIG_CTRL && wr_data[0]
                                |=> cal_bits[0])
    else $error("calibration did not start");
  cal_length_a: assert property ($fell(cal_bits[0]) |-> $past(cal_cnt[0]) == CAL_LAST)
    else $error("calibration ended early");
  cal_clear_a: assert property (cal_done[0] && !(wr_en && wr_addr == REG_DIG_CTRL)
                                |=> !cal_bits[0] && calibrated_out[0])
    else $error("trigger bit not cleared");
  surround_phase_a: assert property (surround && $past(surround) && run && $past(run)
                                     |-> frame_sync_one_out == frame_sync_two_out)
    else $error("frame syncs out of phase");
  gpio_dir_a: assert property (wr_en && wr_addr == REG_GPIO_DIR
                               |=> gpio_oe_out == $past(wr_data))
    else $error("direction not written");
  gpo_time_a: assert property ($changed(gpio_out)
                               |-> $past(step[0]) && $past(idx[0]) == GPO_IDX - 6'h01)
    else $error("gpio output moved off time");
  pd_park_a: assert property (!run |=> serial_bit_clock_one_out && !frame_sync_one_out
                              && serial_bit_clock_two_out && !frame_sync_two_out)
    else $error("clocks not parked in power-down");

  cal_done_c: cover property (cal_done[0]);
  surround_c: cover property (surround && frame_start[1]);
  fifo_full_c: cover property (adc_valid_in && !adc_ready_out);
  reg_write_c: cover property (wr_en && wr_addr == REG_MODE);
endmodule

/* File: verif/dsp_model.sv */
// controller-side model of a serial port: at each frame sync sends one frame, captures one
`timescale 1ns/1ps
module dsp_model (
  // clock and port pins
  input  wire logic        clk_in,
  input  wire logic        sclk_in,
  input  wire logic        fsync_in,
  input  wire logic        sout_in,
  output logic             sin_out = 1'b0,
  // frame words
  input  wire logic [63:0] tx_in,
  output logic      [63:0] rx_out = 64'h0,
  output logic             frame_out = 1'b0
);
  logic [63:0] cur = 64'h0;
  logic [63:0] rx = 64'h0;
  logic [5:0]  k = 6'h00;
  logic        sclk_q = 1'b1;
  // data moves at bit start, well clear of the mid-bit sample
  always @(posedge clk_in) begin
    sclk_q <= sclk_in;
    frame_out <= 1'b0;
    if (sclk_in && !sclk_q && fsync_in) begin
      cur <= tx_in;
      sin_out <= tx_in[63];
      k <= 6'h01;
      rx_out <= rx;
      frame_out <= 1'b1;
    end else if (sclk_in && !sclk_q) begin
      sin_out <= cur[6'h3F-k];
      k <= k + 6'h01;
    end
    // capture at the falling bit clock, mid bit
    if (!sclk_in && sclk_q)
      rx <= {rx[62:0], sout_in};
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the codec housekeeping block
`timescale 1ns/1ps
module tb;
  import codec_pkg::*;
  logic clk, nrst, pd, sin, sc1, fs1, so1, sc2, fs2, so2, frm, sv;
  // master clocks start known so their toggles never lock at unknown
  logic mck = 1'b0;
  logic mcm = 1'b0;
  logic [7:0] gin, gout, goe;
  logic [15:0] smp;
  logic [3:0] ovf;
  logic [1:0] cal, done_cal;
  logic ready, flt, cm, tog;
  logic [REG_COUNT*8-1:0] st;
  logic [63:0] tx, rx, rx2;
  int mismatches, n_checks, acc, bad;
  // table of register writes and expected readback
  logic [4:0] r_a [4] = '{REG_GPIO_DIR, REG_LINE2_GAIN, REG_OVF_CLR, REG_MODE};
  logic [7:0] r_d [4] = '{8'hFF, 8'h3C, 8'h01, 8'h0C};
  logic [7:0] r_b [4] = '{8'hFF, 8'h3C, 8'h00, 8'h0C};

  codec_control dut (.clk_in(clk), .nrst_in(nrst), .power_down_pin_in(pd),
    .audio_master_clock_in(mck), .modem_master_clock_in(mcm),
    .serial_bit_clock_one_out(sc1), .frame_sync_one_out(fs1), .serial_out_one_out(so1),
    .serial_in_one_in(sin), .serial_bit_clock_two_out(sc2), .frame_sync_two_out(fs2),
    .serial_out_two_out(so2), .gpio_in(gin), .gpio_out(gout), .gpio_oe_out(goe),
    .adc_sample_in(smp), .adc_valid_in(sv), .adc_ready_out(ready),
    .adc_overflow_in(ovf), .cal_active_out(cal), .calibrated_out(done_cal),
    .analog_float_out(flt), .common_mode_out(cm), .mute_toggle_out(tog),
    .settings_out(st));
  dsp_model peer (.clk_in(clk), .sclk_in(sc1), .fsync_in(fs1), .sout_in(so1),
    .sin_out(sin), .tx_in(tx), .rx_out(rx), .frame_out(frm));
  dsp_model peer2 (.clk_in(clk), .sclk_in(sc2), .fsync_in(fs2), .sout_in(so2),
    .sin_out(), .tx_in(64'h0), .rx_out(rx2), .frame_out());

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // master clock at its fastest sampled rate
  always @(negedge clk) mck <= ~mck;
  // modem clock at half rate, so surround must really ignore it
  always @(negedge mck) mcm <= ~mcm;

  function automatic logic [63:0] wf(logic [4:0] a, logic [7:0] d, logic w);
    wf = {8'h5A, 24'h00_0000, d, w, 2'b00, a, 16'h0000};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge frm);
    @(negedge clk);
  endtask
  // one write frame, then an idle frame at the same address
  task automatic xfer(input logic [4:0] a, input logic [7:0] d);
    tx = wf(a, d, 1'b1);
    frames(1);
    tx = wf(a, 8'h00, 1'b0);
    frames(1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    conclude;
  end

  initial begin
    nrst = 1'b0; pd = 1'b1; gin = 8'h3C; smp = 16'h0000;
    sv = 1'b0; ovf = 4'h0; tx = 64'h0; mismatches = 0; n_checks = 0;
    repeat (4) @(negedge clk);
    chk(sc1, 1'b1);
    chk(fs1, 1'b0);
    chk(cm, 1'b1);
    chk(st[8*REG_LINE1_GAIN +: 8], LINE_GAIN_RST);
    chk(st[8*REG_MONO_CTRL +: 8], 8'hF6);
    chk(st[8*REG_M2_IN_CTRL +: 8], 8'h7C);
    chk(goe, 8'h00);
    chk(tog, 1'b1);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(r_a[i], r_d[i]);
      frames(3);
      chk(rx[15:8], r_b[i]);
    end
    chk(goe, 8'hFF);
    chk(gout, 8'h5A);
    chk(rx[31:24], 8'h3C);
    // surround mode is on: both syncs must match every cycle
    bad = 0;
    repeat (600) @(negedge clk) if (fs1 !== fs2) bad++;
    chk(64'(bad), 64'h0);
    ovf = 4'h5;
    @(negedge clk) ovf = 4'h0;
    frames(3);
    chk(rx[19:16], 4'h5);
    xfer(REG_OVF_CLR, 8'h01);
    frames(3);
    chk(rx[19:16], 4'h4);
    // fill the sample fifo until it refuses, far side popping once a frame
    acc = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      smp = 16'h1000 + 16'(acc);
      sv = 1'b1;
      if (ready) acc++;
    end
    @(negedge clk) sv = 1'b0;
    chk(64'(acc), 64'd32);
    bad = 0;
    while (rx[63:48] === 16'h0000 && bad < 6) begin
      frames(1);
      bad++;
    end
    chk(rx[63:48], 16'h1000);
    frames(31);
    chk(rx[63:48], 16'h101F);
    frames(3);
    chk(rx[63:48], 16'h0000);
    chk(ready, 1'b1);
    xfer(REG_DIG_CTRL, 8'h01);
    chk(cal, 2'b01);
    chk(done_cal, 2'b00);
    // a real sample queued mid calibration must still go out as zero
    smp = 16'hABCD;
    sv = 1'b1;
    @(negedge clk) sv = 1'b0;
    frames(2);
    chk(rx[63:48], 16'h0000);
    chk(rx[1:0], 2'b01);
    chk(rx2[1:0], 2'b01);
    xfer(REG_DIG_CTRL, 8'h00);
    chk(cal, 2'b01);
    pd = 1'b0;
    repeat (10) @(negedge clk);
    chk(sc1, 1'b1);
    chk(fs1, 1'b0);
    chk(flt, 1'b1);
    chk(goe, 8'hFF);
    // wake under reset, as the controller is advised to
    nrst = 1'b0;
    pd = 1'b1;
    repeat (4) @(negedge clk);
    chk(cal, 2'b00);
    chk(goe, 8'h00);
    chk(st[8*REG_MODE +: 8], 8'h00);
    nrst = 1'b1;
    frames(2);
    chk(cal, 2'b00);
    conclude;
  end
endmodule
